// ### hw/mdu_defs.vh
`ifndef MDU_DEFS_VH
`define MDU_DEFS_VH
`define MDU_OP_W 5
`define MDU_OP_HMUL 5'h00
`define MDU_OP_HMLA 5'h01
`define MDU_OP_HMLS 5'h02
`define MDU_OP_DADD 5'h03
`define MDU_OP_DADDX 5'h04
`define MDU_OP_DSUB 5'h05
`define MDU_OP_DSUBX 5'h06
`define MDU_OP_HBB 5'h07
`define MDU_OP_HBT 5'h08
`define MDU_OP_HTB 5'h09
`define MDU_OP_HTT 5'h0a
`define MDU_OP_WB 5'h0b
`define MDU_OP_WT 5'h0c
`define MDU_OP_UMUL 5'h0d
`define MDU_OP_UMLA 5'h0e
`define MDU_OP_SMUL 5'h0f
`define MDU_OP_SMLA 5'h10
`define MDU_OP_SGN_DIV 5'h11
`define MDU_OP_UNS_DIV 5'h12
`define MDU_ROUND_CONST 64'h0000_0000_8000_0000
`define MDU_DIV_STEPS 6'h20
`endif

// ### hw/mdu_unit.v
`timescale 1ns/100ps
`include "mdu_defs.vh"
// integer multiply and divide unit beside the core's register file
// every multiply answers one cycle after the edge that takes it
// a divide raises busy; its answer is launched 33 edges after the take
// a zero divisor answers one cycle later with a zero quotient
// start is ignored while busy, and an unknown op answers zero
// op codes, shared with the decoder through the header:
//   HMUL     high word of the signed product, optionally rounded
//   HMLA     addend plus that high word
//   HMLS     addend minus that high word
//   DADD     sum of the two halfword products
//   DADDX    the same with the second factor's halfwords swapped
//   DSUB     bottom product minus top product
//   DSUBX    the same with the second factor's halfwords swapped
//   HBB      bottom half times bottom half
//   HBT      bottom half times top half
//   HTB      top half times bottom half
//   HTT      top half times top half
//   WB       word times bottom half, upper 32 of 48 bits
//   WT       word times top half, upper 32 of 48 bits
//   UMUL     unsigned 64-bit product
//   UMLA     unsigned product plus the accumulator pair
//   SMUL     signed 64-bit product
//   SMLA     signed product plus the accumulator pair
//   SGN_DIV  signed quotient, truncated toward zero
//   UNS_DIV  unsigned quotient
// timing, counted from the edge that takes start:
//   multiply: result_valid and the words one cycle later
//   zero divide: the same, with every word zero
//   divide: busy from the next cycle, 32 steps, then the answer
//   the answer and the fall of busy come together
// hazard: operands are read only at the taking edge, so the core
// may change them at once; the divider keeps its own copies
// limitation: the most negative dividend over minus one returns
// that same dividend, since the quotient does not fit
module mdu_unit #(
  parameter DIV_STEPS = `MDU_DIV_STEPS
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [4:0] op,
  input wire round_en,
  input wire [31:0] first_factor,
  input wire [31:0] second_factor,
  input wire [31:0] addend_source,
  input wire [31:0] low_result_word_in,
  input wire [31:0] high_result_word_in,
  output reg [31:0] low_result_word,
  output reg [31:0] high_result_word,
  output reg result_valid,
  output reg wide_result,
  output reg overflow_set,
  output reg sticky_overflow,
  output reg busy
);

  // state codes of the divider sequencer
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV = 1'b1;

  // registers of the divider; each has its next value beside it
  // sequencer state and its next value
  reg st_q;
  reg st_d;

  // steps still to run in the current divide
  reg [5:0] cnt_q;
  reg [5:0] cnt_d;

  // dividend magnitude shifting out, quotient bits shifting in
  reg [31:0] quo_q;
  reg [31:0] quo_d;

  // partial remainder, one bit wider than the divisor
  reg [32:0] rem_q;
  reg [32:0] rem_d;

  // divisor magnitude held for the whole divide
  reg [31:0] dvs_q;
  reg [31:0] dvs_d;

  // sign to put back on the quotient at the end
  reg neg_q;
  reg neg_d;

  // result mux outputs for the single-cycle operations
  reg [63:0] mres;
  reg mwide;

  // decode of the op code into the few selects the datapath needs
  // dual add family, both orders
  wire op_dual_add = (op == `MDU_OP_DADD) || (op == `MDU_OP_DADDX);

  // reversed dual forms swap the second factor's halfwords
  wire swap = (op == `MDU_OP_DADDX) || (op == `MDU_OP_DSUBX);

  // halfword selectors: top of the first factor, top of the second
  wire sel_x = (op == `MDU_OP_HTB) || (op == `MDU_OP_HTT);
  wire sel_y = (op == `MDU_OP_HBT) || (op == `MDU_OP_HTT) || (op == `MDU_OP_WT);

  // divide family and its signed member
  wire is_div = (op == `MDU_OP_SGN_DIV) || (op == `MDU_OP_UNS_DIV);
  wire sgn = (op == `MDU_OP_SGN_DIV);

  // requests taken this edge; nothing is taken while dividing
  wire idle = (st_q == ST_IDLE);
  wire mul_take = idle && start && !is_div;
  wire zdiv_take = idle && start && is_div && (second_factor == 32'h0);
  wire div_take = idle && start && is_div && (second_factor != 32'h0);
  wire div_done = (st_q == ST_DIV) && (cnt_q == 6'h0);

  // these products are wide enough that no bits are lost
  // full 32 by 32 products, signed and unsigned
  wire signed [63:0] sprod = $signed(first_factor) * $signed(second_factor);
  wire [63:0] uprod = first_factor * second_factor;

  // optional rounding before the high word is taken
  wire [63:0] rprod = round_en ? sprod + `MDU_ROUND_CONST : sprod;
  wire [31:0] hi_word = rprod[63:32];

  // dual halfword products; 16 by 16 signed cannot overflow 32 bits
  wire [31:0] m2 = swap ? {second_factor[15:0], second_factor[31:16]} : second_factor;
  wire signed [31:0] pbot = $signed(first_factor[15:0]) * $signed(m2[15:0]);
  wire signed [31:0] ptop = $signed(first_factor[31:16]) * $signed(m2[31:16]);

  // sum one bit wider so that signed overflow shows in the top two bits
  wire [32:0] dsum = {pbot[31], pbot} + {ptop[31], ptop};
  wire dovf = dsum[32] ^ dsum[31];

  // difference of the bottom and top products
  wire [31:0] ddif = pbot - ptop;

  // selected halfwords, each taken as signed
  wire [15:0] ha = sel_x ? first_factor[31:16] : first_factor[15:0];
  wire [15:0] hb = sel_y ? second_factor[31:16] : second_factor[15:0];

  // halfword by halfword and word by halfword products
  wire signed [31:0] hprod = $signed(ha) * $signed(hb);
  wire signed [47:0] wprod = $signed(first_factor) * $signed(hb);

  // accumulator pair handed back by the register file
  wire [63:0] acc = {high_result_word_in, low_result_word_in};

  // magnitudes of the divide operands
  wire na = sgn & first_factor[31];
  wire nb = sgn & second_factor[31];
  wire [31:0] ma = na ? 32'h0 - first_factor : first_factor;
  wire [31:0] mb = nb ? 32'h0 - second_factor : second_factor;

  // trial subtraction of one restoring step
  wire [32:0] trial = {rem_q[31:0], quo_q[31]} - {1'b0, dvs_q};

  // truncating quotient: magnitude divided, sign put back afterwards
  wire [31:0] qfin = neg_q ? 32'h0 - quo_q : quo_q;

  // results of the single-cycle group are formed here and captured
  // at the taking edge; long forms fill both words
  // the unit drives no negative, zero or carry flag; only a dual add can raise overflow
  always @* begin
    mres = 64'h0;
    mwide = 1'b0;
    case (op)
      `MDU_OP_HMUL: mres = {32'h0, hi_word};
      `MDU_OP_HMLA: mres = {32'h0, hi_word + addend_source};
      `MDU_OP_HMLS: mres = {32'h0, addend_source - hi_word};
      `MDU_OP_DADD, `MDU_OP_DADDX: mres = {32'h0, dsum[31:0]};
      `MDU_OP_DSUB, `MDU_OP_DSUBX: mres = {32'h0, ddif};
      `MDU_OP_HBB, `MDU_OP_HBT, `MDU_OP_HTB, `MDU_OP_HTT: mres = {32'h0, hprod};
      `MDU_OP_WB, `MDU_OP_WT: mres = {32'h0, wprod[47:16]};
      `MDU_OP_UMUL: begin
        mres = uprod;
        mwide = 1'b1;
      end
      `MDU_OP_UMLA: begin
        mres = uprod + acc;
        mwide = 1'b1;
      end
      `MDU_OP_SMUL: begin
        mres = sprod;
        mwide = 1'b1;
      end
      `MDU_OP_SMLA: begin
        mres = sprod + acc;
        mwide = 1'b1;
      end
      default: mres = 64'h0;
    endcase
  end

  // restoring divider: each step shifts the next dividend bit into
  // the partial remainder and keeps the difference if it is not
  // negative; the kept bit becomes the next quotient bit
  // the step count must stay 32 for a full-width quotient
  // divider next state: load on take, one step per edge, then answer
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    quo_d = quo_q;
    rem_d = rem_q;
    dvs_d = dvs_q;
    neg_d = neg_q;
    case (st_q)
      ST_IDLE: begin
        if (div_take) begin
          quo_d = ma;
          rem_d = 33'h0;
          dvs_d = mb;
          neg_d = na ^ nb;
          cnt_d = DIV_STEPS[5:0];
          st_d = ST_DIV;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          st_d = ST_IDLE;
        end else begin
          if (!trial[32]) begin
            rem_d = trial;
            quo_d = {quo_q[30:0], 1'b1};
          end else begin
            rem_d = {rem_q[31:0], quo_q[31]};
            quo_d = {quo_q[30:0], 1'b0};
          end
          cnt_d = cnt_q - 6'h1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // sequencer state register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // step counter register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 6'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // dividend and quotient shift register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quo_q <= 32'h0;
    end else begin
      quo_q <= quo_d;
    end
  end

  // partial remainder register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rem_q <= 33'h0;
    end else begin
      rem_q <= rem_d;
    end
  end

  // divisor copy register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dvs_q <= 32'h0;
    end else begin
      dvs_q <= dvs_d;
    end
  end

  // quotient sign register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= neg_d;
    end
  end

  // the register file writes the low word always, the high word only
  // when wide_result is high; words stand until the next answer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_result_word <= 32'h0;
      high_result_word <= 32'h0;
      wide_result <= 1'b0;
    end else if (mul_take) begin
      low_result_word <= mres[31:0];
      high_result_word <= mres[63:32];
      wide_result <= mwide;
    end else if (zdiv_take) begin
      low_result_word <= 32'h0;
      high_result_word <= 32'h0;
      wide_result <= 1'b0;
    end else if (div_done) begin
      low_result_word <= qfin;
      high_result_word <= 32'h0;
      wide_result <= 1'b0;
    end
  end

  // one-cycle valid strobe with every answer; divides touch no flag
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= mul_take || zdiv_take || div_done;
    end
  end

  // busy from the edge that takes a divide until its answer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (st_d == ST_DIV);
    end
  end

  // overflow strobe for a dual add whose final sum overflowed
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflow_set <= 1'b0;
    end else begin
      overflow_set <= mul_take && op_dual_add && dovf;
    end
  end

  // sticky overflow: set here, cleared only by reset
  // the core may read the flag at any time
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sticky_overflow <= 1'b0;
    end else if (mul_take && op_dual_add && dovf) begin
      sticky_overflow <= 1'b1;
    end
  end
endmodule // mdu_unit

// ### testbench/mdu_checker.sv
`timescale 1ns/100ps
module mdu_checker (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [4:0] op,
  input wire [31:0] second_factor,
  input wire [31:0] low_result_word,
  input wire [31:0] high_result_word,
  input wire result_valid,
  input wire wide_result,
  input wire overflow_set,
  input wire sticky_overflow,
  input wire busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // taken requests, and taken divides
  wire tk = start && !busy;
  wire dv = tk && (op == 5'h11 || op == 5'h12);
  mul_valid_a: assert property (tk && op < 5'h11 |=> result_valid)
    else $error("multiply result late");
  div_busy_a: assert property (dv && second_factor != 0 |=> busy [*8])
    else $error("divide not busy");
  div_answer_a: assert property (dv && second_factor != 0 |-> ##34 result_valid && $fell(busy))
    else $error("divide answer not on time");
  div_end_a: assert property ($fell(busy) |-> result_valid)
    else $error("busy ended without result");
  zero_div_a: assert property (dv && !second_factor |=> result_valid && !low_result_word)
    else $error("zero divisor result");
  ovf_pulse_a: assert property (overflow_set |-> result_valid)
    else $error("overflow without result");
  sticky_set_a: assert property (overflow_set |=> sticky_overflow)
    else $error("sticky not set");
  sticky_keep_a: assert property (sticky_overflow |=> sticky_overflow)
    else $error("sticky cleared");
  narrow_hi_a: assert property (result_valid && !wide_result |-> !high_result_word)
    else $error("high word not zero");
endmodule // mdu_checker
bind mdu_unit mdu_checker mdu_checker_i (.*);

// ### testbench/mdu_acc_model.sv
`timescale 1ns/100ps
module mdu_acc_model (
  input wire clk,
  input wire resetn,
  input wire result_valid,
  input wire wide_result,
  input wire [31:0] low_result_word,
  input wire [31:0] high_result_word,
  output logic [31:0] low_result_word_in,
  output logic [31:0] high_result_word_in
);
  // register pair that takes every long result back
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {high_result_word_in, low_result_word_in} <= 64'h0;
    end else if (result_valid && wide_result) begin
      {high_result_word_in, low_result_word_in} <= {high_result_word, low_result_word};
    end
  end
endmodule // mdu_acc_model

// ### testbench/mdu_unit_tb_top.sv
`timescale 1ns/100ps
module mdu_unit_tb_top;
  localparam logic [31:0] g = 32'h40000000, x = 32'hfffd0002, y = 32'h50004;
  localparam logic [31:0] m = 32'hffffffff, z = 32'h0, w = 32'h2;
  logic clk = 0, resetn = 0, start = 0, round_en = 0;
  logic [4:0] op = 0;
  logic [31:0] first_factor = 0, second_factor = 0, addend_source = 32'h10;
  logic [31:0] low_result_word_in, high_result_word_in, low_result_word, high_result_word;
  logic result_valid, wide_result, overflow_set, sticky_overflow, busy;
  int bad_count = 0, tests_run = 0;
  // {op, round}, first, second, expected low, expected high
  logic [133:0] rows [19] = '{
    {6'h0, g, 32'h6, 32'h1, z}, {6'h2, g, 32'h6, 32'h11, z}, {6'h5, g, 32'h6, 32'he, z},
    {6'h6, x, y, 32'hfffffff9, z}, {6'h8, x, y, 32'hfffffffe, z}, {6'ha, x, y, 32'h17, z},
    {6'hc, x, y, 32'h16, z}, {6'he, x, y, 32'h8, z}, {6'h10, x, y, 32'ha, z},
    {6'h12, x, y, 32'hfffffff4, z}, {6'h14, x, y, 32'hfffffff1, z},
    {6'h16, x, y, 32'hfffffff4, z}, {6'h18, x, y, 32'hfffffff1, z},
    {6'h1a, m, m, 32'h1, 32'hfffffffe}, {6'h1c, m, w, m, m}, {6'h1e, m, m, 32'h1, z},
    {6'h20, m, w, m, m}, {6'h22, 32'hfffffff9, w, 32'hfffffffd, z},
    {6'h24, 32'hfffffff9, w, 32'h7ffffffc, z}};
  mdu_unit mdu_unit_i (.*);
  mdu_acc_model mdu_acc_model_i (.*);
  always #25 clk = ~clk;
  task chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task wv;
    int n;
    n = 0;
    #1;
    while (result_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("valid", 1, result_valid);
    $display("test op %h done", op);
  endtask
  task issue(input logic [4:0] o, input logic r, input logic [31:0] a, b);
    @(posedge clk);
    start <= 1;
    op <= o;
    round_en <= r;
    first_factor <= a;
    second_factor <= b;
    @(posedge clk);
    start <= 0;
  endtask
  task go(input logic [4:0] o, input logic r, input logic [31:0] a, b);
    issue(o, r, a, b);
    wv;
  endtask
  task end_sim;
    $display("tests %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    foreach (rows[i]) begin
      go(rows[i][133:129], rows[i][128], rows[i][127:96], rows[i][95:64]);
      chk("lo", rows[i][63:32], low_result_word);
      chk("hi", rows[i][31:0], high_result_word);
      chk("wide", rows[i][133:129] >= 5'hd && rows[i][133:129] <= 5'h10, wide_result);
      chk("ovf0", 0, overflow_set);
    end
    chk("sticky", 0, sticky_overflow);
    go(5'h3, 0, 32'h80008000, 32'h80008000);
    chk("ovf", 1, overflow_set);
    chk("sum", 32'h80000000, low_result_word);
    go(5'h7, 0, x, y);
    chk("keep", 1, sticky_overflow);
    go(5'h11, 0, y, z);
    chk("div0", 0, low_result_word);
    // a multiply started while dividing is dropped
    issue(5'h12, 0, 32'h64, 32'h7);
    issue(5'h0, 0, g, 32'h6);
    #1;
    chk("busy", 1, busy);
    chk("drop", 0, result_valid);
    wv;
    chk("quot", 32'he, low_result_word);
    chk("idle", 0, busy);
    // reset in the middle of a divide
    issue(5'h11, 0, 32'h64, 32'h7);
    @(posedge clk);
    resetn <= 0;
    @(posedge clk);
    #1;
    chk("rst", 0, sticky_overflow);
    chk("rst busy", 0, busy);
    chk("rst valid", 0, result_valid);
    @(posedge clk);
    resetn <= 1;
    go(5'h0, 0, g, 32'h6);
    chk("after rst", 1, low_result_word);
    chk("after busy", 0, busy);
    end_sim;
  end
endmodule // mdu_unit_tb_top
